// [hdl/hotplug_map.svh]
// Purpose: Register indices, field positions and reset values of the slot register bank
// Assumes: Indices are word indices; the byte address is four times the index
// Notes: Definitions only, no logic
`ifndef HOTPLUG_MAP_SVH
`define HOTPLUG_MAP_SVH

// Word indices of the registers
`define IDX_SLOT_CAP 10'h054
`define IDX_SLOT_CTL 10'h058
`define IDX_SLOT_STS 10'h05A
`define IDX_DEV_CAP2 10'h064
`define IDX_DEV_CTL2 10'h068
`define IDX_DEV_STS2 10'h06A
`define IDX_IRQ_STATUS 10'h080
`define IDX_IRQ_ENABLE 10'h081
`define IDX_IRQ_CLEAR 10'h082

// Slot capabilities fields
`define CAP_BUTTON 0
`define CAP_PWR_CTL 1
`define CAP_LATCH 2
`define CAP_ATTN_IND 3
`define CAP_PWR_IND 4
`define CAP_HOTPLUG 5
`define CAP_INTERLOCK 17
`define CAP_WMASK 32'h0002003F
`define CAP_RESET 32'h00000000

// Slot control fields
`define CTL_BTN_EN 0
`define CTL_PFAULT_EN 1
`define CTL_LATCH_EN 2
`define CTL_PRES_EN 3
`define CTL_CMD_EN 4
`define CTL_IRQ_MASTER_EN 5
`define CTL_ATTN_LO 6
`define CTL_PWR_IND_LO 8
`define CTL_PWR_OFF 10
`define CTL_INTERLOCK 11
`define CTL_LINK_EN 12
`define CTL_STORE_MASK 16'h17FF
`define CTL_RESET 16'h01C0

// Slot status fields
`define STS_LATCH_STATE 5
`define STS_PRES_STATE 6
`define STS_INTERLOCK 7
`define STS_LINK_FLAG 8
`define STS_RESET_PRES 1'b1

// Event vector positions, shared by the interrupt registers
`define EV_BUTTON 0
`define EV_PFAULT 1
`define EV_LATCH 2
`define EV_PRES 3
`define EV_CMD 4
`define EV_LINK 5
`define EV_COUNT 6

`endif

// [hdl/hotplug_pkg.sv]
// Purpose: Types shared by the slot register bank
// Assumes: Constants live in hotplug_map.svh
// Notes: Nothing here is imported; users write hotplug_pkg::name
`default_nettype none
package hotplug_pkg;
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_t;
  typedef logic [5:0] slot_event_t;
  typedef logic [15:0] half_t;
endpackage
`default_nettype wire

// [hdl/hotplug_slot_status_regs.sv]
// Purpose: Slot control, slot status and interrupt registers of one hot-plug port over APB
// Assumes: Slot inputs are synchronous to mclk; event inputs are one-cycle pulses
// Notes: APB answers with no wait state; read data is captured in the setup cycle
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "hotplug_map.svh"

// Notes on behaviour
// - Interlock control bit always reads back as zero.
// - Writing one to interlock control toggles the interlock; zero does nothing.
// - Without interlock capability the control bit is read-only zero.
// - With link change enable set, a link-active change raises interrupt or wake.
// - Attention button press sets its flag; write-one-to-clear, resets to zero.
// - Power fault from the power controller sets its flag; write-one-to-clear.
// - Any latch sensor change sets its flag; write-one-to-clear.
// - Any card presence change sets its flag; write-one-to-clear.
// - Command completion by the controller sets its flag; write-one-to-clear.
// - Latch state bit shows live latch: zero closed, one open; resets zero.
// - Presence state bit shows card presence: zero empty, one present; resets one.
// - Interlock status bit shows interlock: zero disengaged, one engaged.
// - Link-active bit changing value sets its flag; write-one-to-clear.
// - Slot interrupt needs the master hot-plug interrupt enable as well.
// - Control bits zero to four enable button, fault, latch, presence, command events.
module hotplug_slot_status_regs (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic button_press,
  input wire logic power_fault,
  input wire logic cmd_done,
  input wire logic latch_open,
  input wire logic card_present,
  input wire logic interlock_engaged,
  input wire logic link_active_bit,
  output logic interlock_toggle,
  output logic cmd_issue,
  output logic [1:0] attn_ind,
  output logic [1:0] pwr_ind,
  output logic pwr_off,
  output logic hotplug_irq,
  output logic wake_event,
  output logic irq
);

  // Bus state and stored registers
  hotplug_pkg::bus_state_t bus_state;
  hotplug_pkg::bus_state_t next_bus_state;
  logic [31:0] slot_capabilities_reg;
  hotplug_pkg::half_t slot_ctl;
  hotplug_pkg::slot_event_t slot_flags;
  hotplug_pkg::slot_event_t irq_status;
  hotplug_pkg::slot_event_t irq_enable;
  logic latch_state;
  logic presence_state;
  logic link_seen;

  // Address decode, on the word index
  wire [9:0] word_idx = paddr[11:2];
  wire hit_cap = (word_idx == `IDX_SLOT_CAP);
  wire hit_ctl = (word_idx == `IDX_SLOT_CTL);
  wire hit_sts = (word_idx == `IDX_SLOT_STS);
  wire hit_rsvd = (word_idx == `IDX_DEV_CAP2) || (word_idx == `IDX_DEV_CTL2)
      || (word_idx == `IDX_DEV_STS2);
  wire hit_irq_sts = (word_idx == `IDX_IRQ_STATUS);
  wire hit_irq_en = (word_idx == `IDX_IRQ_ENABLE);
  wire hit_irq_clr = (word_idx == `IDX_IRQ_CLEAR);
  wire hit_any = hit_cap | hit_ctl | hit_sts | hit_rsvd | hit_irq_sts | hit_irq_en
      | hit_irq_clr;

  // Bus phases; a write lands only at the edge that completes the access
  wire setup_phase = psel & ~penable;
  wire access_done = (bus_state == hotplug_pkg::BUS_ANSWER) & psel & penable & pready;
  wire wr_fire = access_done & pwrite;
  wire [31:0] byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [15:0] half_mask = byte_mask[15:0];
  wire [15:0] wdata16 = pwdata[15:0];

  // Capability bits that gate slot control fields
  wire cap_button = slot_capabilities_reg[`CAP_BUTTON];
  wire cap_pwr_ctl = slot_capabilities_reg[`CAP_PWR_CTL];
  wire cap_latch = slot_capabilities_reg[`CAP_LATCH];
  wire cap_attn = slot_capabilities_reg[`CAP_ATTN_IND];
  wire cap_pwr_ind = slot_capabilities_reg[`CAP_PWR_IND];
  wire cap_hotplug = slot_capabilities_reg[`CAP_HOTPLUG];
  wire cap_interlock = slot_capabilities_reg[`CAP_INTERLOCK];

  // A gated field reads zero and takes no write while its capability is off
  wire [15:0] ctl_gate = {
    3'h0,
    1'b1,
    1'b0,
    cap_pwr_ctl,
    {2{cap_pwr_ind}},
    {2{cap_attn}},
    cap_hotplug,
    cap_hotplug,
    1'b1,
    cap_latch,
    cap_pwr_ctl,
    cap_button
  };
  wire [15:0] ctl_eff = slot_ctl & ctl_gate & `CTL_STORE_MASK;
  wire [15:0] ctl_wr_mask = half_mask & ctl_gate & `CTL_STORE_MASK;
  wire ctl_write = wr_fire & hit_ctl & (|half_mask);

  // Interlock toggle: one written to bit 11, only with the interlock present
  wire next_interlock_toggle = wr_fire & hit_ctl & pstrb[1] & cap_interlock
      & pwdata[`CTL_INTERLOCK];

  // Slot control next value; bit 11 is never stored so it reads zero
  wire [15:0] next_slot_ctl = ctl_write
      ? ((slot_ctl & ~ctl_wr_mask) | (wdata16 & ctl_wr_mask))
      : slot_ctl;

  // Capabilities stay writable so firmware can describe the slot
  wire [31:0] cap_wr_mask = byte_mask & `CAP_WMASK;
  wire [31:0] next_slot_capabilities_reg = (wr_fire & hit_cap)
      ? ((slot_capabilities_reg & ~cap_wr_mask) | (pwdata & cap_wr_mask))
      : slot_capabilities_reg;

  // Slot events; changes are seen against the registered copy of each level
  wire latch_change = latch_open ^ latch_state;
  wire pres_change = card_present ^ presence_state;
  wire link_change = link_active_bit ^ link_seen;
  wire [5:0] slot_event = {
    link_change,
    cmd_done,
    pres_change,
    latch_change,
    power_fault,
    button_press
  };

  // Write-one-to-clear vectors for slot status and the interrupt status
  wire sts_clear_en = wr_fire & hit_sts;
  wire [5:0] sts_clear = sts_clear_en ? {
    wdata16[`STS_LINK_FLAG] & half_mask[`STS_LINK_FLAG],
    wdata16[4:0] & half_mask[4:0]
  } : 6'h00;
  wire [5:0] irq_clear = (wr_fire & hit_irq_clr) ? (pwdata[5:0] & byte_mask[5:0]) : 6'h00;
  wire [5:0] next_slot_flags;
  wire [5:0] next_irq_status;

  // One sticky flag per event; the event beats a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < `EV_COUNT; gi = gi + 1) begin : g_flag
      assign next_slot_flags[gi] = slot_event[gi]
          | (slot_flags[gi] & ~sts_clear[gi]);
      assign next_irq_status[gi] = slot_event[gi] | (irq_status[gi] & ~irq_clear[gi]);
    end
  endgenerate

  // Interrupt enable register
  wire [5:0] irq_en_mask = byte_mask[5:0];
  wire [5:0] next_irq_enable = (wr_fire & hit_irq_en)
      ? ((irq_enable & ~irq_en_mask) | (pwdata[5:0] & irq_en_mask))
      : irq_enable;

  // Per-event enables in event-vector order
  wire [5:0] slot_event_en = {
    ctl_eff[`CTL_LINK_EN],
    ctl_eff[`CTL_CMD_EN],
    ctl_eff[`CTL_PRES_EN],
    ctl_eff[`CTL_LATCH_EN],
    ctl_eff[`CTL_PFAULT_EN],
    ctl_eff[`CTL_BTN_EN]
  };
  wire [5:0] enabled_flags = slot_flags & slot_event_en;

  // Hot-plug interrupt needs the master enable; wake does not
  wire next_hotplug_irq = ctl_eff[`CTL_IRQ_MASTER_EN] & (|enabled_flags);
  // Command completion is an interrupt source only, never a wake source
  wire next_wake_event = |(enabled_flags & 6'h2F);
  wire next_irq = |(irq_status & irq_enable);

  // Interlock status is only meaningful when an interlock is fitted
  wire interlock_rd = cap_interlock & interlock_engaged;

  // Slot status read value; reserved bits 15:9 read zero
  wire [15:0] sts_rd = {
    7'h00,
    slot_flags[`EV_LINK],
    interlock_rd,
    presence_state,
    latch_state,
    slot_flags[4:0]
  };

  // Read mux; reserved and write-only registers read zero
  wire [31:0] rd_cap = hit_cap ? slot_capabilities_reg : 32'h0000_0000;
  wire [31:0] rd_ctl = hit_ctl ? {16'h0000, ctl_eff} : 32'h0000_0000;
  wire [31:0] rd_sts = hit_sts ? {16'h0000, sts_rd} : 32'h0000_0000;
  wire [31:0] rd_irq_sts = hit_irq_sts ? {26'h0, irq_status} : 32'h0000_0000;
  wire [31:0] rd_irq_en = hit_irq_en ? {26'h0, irq_enable} : 32'h0000_0000;
  wire [31:0] read_mux = rd_cap | rd_ctl | rd_sts | rd_irq_sts | rd_irq_en;

  // Answer data and error are captured in the setup cycle
  wire [31:0] next_prdata = (setup_phase & ~pwrite) ? read_mux : 32'h0000_0000;
  wire next_pslverr = setup_phase & ~hit_any;
  wire next_pready = (bus_state == hotplug_pkg::BUS_IDLE) & setup_phase;

  // Bus phase tracking; one access cycle per transfer
  always_comb begin
    next_bus_state = bus_state;
    unique case (bus_state)
      hotplug_pkg::BUS_IDLE: begin
        if (setup_phase) begin
          next_bus_state = hotplug_pkg::BUS_ANSWER;
        end
      end
      hotplug_pkg::BUS_ANSWER: begin
        next_bus_state = hotplug_pkg::BUS_IDLE;
      end
    endcase
  end

  // Bus answer flops
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      bus_state <= hotplug_pkg::BUS_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      bus_state <= next_bus_state;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // Software-written registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      slot_capabilities_reg <= `CAP_RESET;
      slot_ctl <= `CTL_RESET;
      irq_enable <= 6'h00;
    end else if (ce) begin
      slot_capabilities_reg <= next_slot_capabilities_reg;
      slot_ctl <= next_slot_ctl;
      irq_enable <= next_irq_enable;
    end
  end

  // Sticky flags; latched levels give the live state bits
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      slot_flags <= 6'h00;
      irq_status <= 6'h00;
      latch_state <= 1'b0;
      presence_state <= `STS_RESET_PRES;
      link_seen <= 1'b0;
    end else if (ce) begin
      slot_flags <= next_slot_flags;
      irq_status <= next_irq_status;
      latch_state <= latch_open;
      presence_state <= card_present;
      link_seen <= link_active_bit;
    end
  end

  // Slot-facing outputs; indicators follow the gated control fields
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      interlock_toggle <= 1'b0;
      cmd_issue <= 1'b0;
      attn_ind <= 2'h0;
      pwr_ind <= 2'h0;
      pwr_off <= 1'b0;
    end else if (ce) begin
      interlock_toggle <= next_interlock_toggle;
      cmd_issue <= ctl_write;
      attn_ind <= ctl_eff[`CTL_ATTN_LO +: 2];
      pwr_ind <= ctl_eff[`CTL_PWR_IND_LO +: 2];
      pwr_off <= ctl_eff[`CTL_PWR_OFF];
    end
  end

  // Interrupt outputs lag their sources by one cycle so they come from flops
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      hotplug_irq <= 1'b0;
      wake_event <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      hotplug_irq <= next_hotplug_irq;
      wake_event <= next_wake_event;
      irq <= next_irq;
    end
  end

endmodule
`default_nettype wire

// [sim/slot_regs_checker.sv]
// Purpose: Port checks for the slot register bank
// Assumes: Zero-wait APB answers
// Notes: Bound into every bank instance
`timescale 1ns/1ps
`default_nettype none
module slot_regs_checker (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic latch_open,
  input wire logic card_present,
  input wire logic interlock_engaged,
  input wire logic interlock_toggle,
  input wire logic hotplug_irq,
  input wire logic irq
);
  // Decoded access phase
  wire logic [9:0] idx = paddr[11:2];
  wire logic rd = pready && !pwrite;
  wire logic wr = psel && penable && pwrite;
  wire logic ctl_wr = wr && idx == 10'h058 && pstrb[1];
  wire logic rsvd = idx == 10'h064 || idx == 10'h068 || idx == 10'h06A;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  ready_a: assert property (ce && psel && !penable |=> pready)
    else $error("no ready in access phase");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer not zero");
  eic_zero_a: assert property (rd && idx == 10'h058 |-> !prdata[11])
    else $error("interlock control read nonzero");
  toggle_cause_a: assert property (interlock_toggle |-> $past(ctl_wr && pwdata[11]))
    else $error("toggle without write");
  toggle_zero_a: assert property (ctl_wr && !pwdata[11] |=> !interlock_toggle)
    else $error("toggle on zero write");
  rsvd_zero_a: assert property (rd && rsvd |-> prdata == 32'h0 && !pslverr)
    else $error("reserved register not zero");
  state_bits_a: assert property (rd && idx == 10'h05A |-> prdata[31:9] == 23'h0 &&
    prdata[6:5] == $past({card_present, latch_open}, 2) &&
    (!prdata[7] || $past(interlock_engaged)))
    else $error("slot state bits wrong");
  irq_drop_a: assert property ($fell(irq) |-> $past(wr, 2))
    else $error("interrupt dropped without write");
  hp_drop_a: assert property ($fell(hotplug_irq) |-> $past(wr, 2))
    else $error("hot-plug interrupt dropped without write");
  // Main scenarios
  toggle_c: cover property (interlock_toggle);
  drop_c: cover property ($fell(irq));
  refuse_c: cover property (pslverr);
endmodule
bind hotplug_slot_status_regs slot_regs_checker u_slot_regs_checker (
  .mclk, .rstn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .pready, .pslverr, .latch_open, .card_present, .interlock_engaged,
  .interlock_toggle, .hotplug_irq, .irq
);
`default_nettype wire

// [sim/slot_sensors.sv]
// Purpose: Slot sensors, interlock and hot-plug controller model
// Assumes: Bench requests events through poke
// Notes: Levels flip on request; slow delays completion
`timescale 1ns/1ps
`default_nettype none
module slot_sensors (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [4:0] poke,
  input wire logic slow,
  input wire logic interlock_toggle,
  input wire logic cmd_issue,
  output logic button_press,
  output logic power_fault,
  output logic cmd_done,
  output logic latch_open,
  output logic card_present,
  output logic interlock_engaged,
  output logic link_active_bit
);
  logic [4:0] pipe;
  // Board reset: latch closed, card seated
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      {button_press, power_fault, cmd_done, latch_open} <= 4'h0;
      {card_present, interlock_engaged, link_active_bit} <= 3'h4;
      pipe <= 5'h00;
    end else begin
      button_press <= poke[0];
      power_fault <= poke[1];
      latch_open <= latch_open ^ poke[2];
      card_present <= card_present ^ poke[3];
      link_active_bit <= link_active_bit ^ poke[4];
      interlock_engaged <= interlock_engaged ^ interlock_toggle;
      pipe <= {pipe[3:0], cmd_issue};
      cmd_done <= slow ? pipe[4] : cmd_issue;
    end
  end
endmodule
`default_nettype wire

// [sim/tb.sv]
// Purpose: Self-checking bench for the slot register bank
// Assumes: APB master waits for pready
// Notes: Table of plain accesses, then hand tests
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {logic w; logic [9:0] idx; logic [31:0] v; logic err;} row_t;
  logic mclk = 1'h0;
  logic rstn, ce, psel, penable, pwrite, slow, err, button_press, power_fault;
  logic cmd_done, latch_open, card_present, interlock_engaged, link_active_bit;
  logic interlock_toggle, cmd_issue, pready, pslverr, hotplug_irq, wake_event, irq, pwr_off;
  logic [1:0] attn_ind, pwr_ind;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, fb, ib;
  logic [3:0] pstrb;
  logic [4:0] poke;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  int tgl = 0;
  // Reset values, reserved and refused places
  row_t rows [12] = '{
    '{1'h0, 10'h054, 32'h0, 1'h0},
    '{1'h0, 10'h058, 32'h0, 1'h0},
    '{1'h0, 10'h05A, 32'h40, 1'h0},
    '{1'h1, 10'h064, 32'hFFFFFFFF, 1'h0},
    '{1'h0, 10'h064, 32'h0, 1'h0},
    '{1'h1, 10'h068, 32'hFFFF, 1'h0},
    '{1'h0, 10'h068, 32'h0, 1'h0},
    '{1'h0, 10'h06A, 32'h0, 1'h0},
    '{1'h1, 10'h058, 32'h800, 1'h0},
    '{1'h0, 10'h058, 32'h0, 1'h0},
    '{1'h0, 10'h082, 32'h0, 1'h0},
    '{1'h0, 10'h010, 32'h0, 1'h1}
  };
  always #2.5 mclk = ~mclk;
  hotplug_slot_status_regs u_hotplug_slot_status_regs (
    .mclk, .rstn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .button_press, .power_fault, .cmd_done, .latch_open,
    .card_present, .interlock_engaged, .link_active_bit, .interlock_toggle,
    .cmd_issue, .attn_ind, .pwr_ind, .pwr_off, .hotplug_irq, .wake_event, .irq
  );
  slot_sensors u_slot_sensors (
    .mclk, .rstn, .poke, .slow, .interlock_toggle, .cmd_issue, .button_press,
    .power_fault, .cmd_done, .latch_open, .card_present, .interlock_engaged,
    .link_active_bit
  );
  // Hang guard and toggle pulse count
  always @(posedge mclk) begin
    cyc++;
    if (interlock_toggle === 1'h1) tgl++;
    if (cyc == 3000) begin
      err_total++;
      stop_test;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // One APB transfer; pk pokes the partner in the setup cycle
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d,
      input logic [4:0] pk = 5'h00);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    poke <= pk;
    @(posedge mclk);
    penable <= 1'h1;
    poke <= 5'h00;
    @(posedge mclk);
    // Only the bench timeout ends a wait for the answer
    while (pready !== 1'h1) begin
      @(posedge mclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdc(input logic [9:0] idx, input logic [31:0] m, input logic [31:0] e);
    apb(1'h0, idx, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    {rstn, psel, penable, pwrite, slow} = 5'h00;
    ce = 1'h1;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    poke = 5'h00;
    tick(5);
    rstn <= 1'h1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].idx, rows[i].v);
      if (!rows[i].w) begin
        chk(rd, rows[i].v);
        chk(32'(err), 32'(rows[i].err));
      end
    end
    chk(tgl, 0);
    // Capabilities on: interlock toggles once, bit 11 reads zero
    apb(1'h1, 10'h081, 32'h3F);
    apb(1'h1, 10'h054, 32'h0002003F);
    rdc(10'h054, 32'hFFFFFFFF, 32'h0002003F);
    apb(1'h1, 10'h058, 32'h1E7F);
    tick(6);
    chk(tgl, 1);
    rdc(10'h058, 32'hFFFFFFFF, 32'h167F);
    chk(32'({attn_ind, pwr_ind, pwr_off}), 32'h0D);
    rdc(10'h05A, 32'hFFFFFFFF, 32'hD0);
    chk(32'({hotplug_irq, irq}), 32'h3);
    apb(1'h1, 10'h05A, 32'h1FF);
    apb(1'h1, 10'h082, 32'h3F);
    tick(3);
    chk(32'({hotplug_irq, wake_event, irq}), 32'h0);
    // Button, fault, latch, presence and link events each set their own flag and raise hotplug_irq, wake_event and irq
    for (int k = 0; k < 5; k++) begin
      fb = (k == 4) ? 32'h100 : 32'h1 << k;
      ib = (k == 4) ? 32'h20 : 32'h1 << k;
      poke <= 5'h01 << k;
      @(posedge mclk);
      poke <= 5'h00;
      tick(4);
      rdc(10'h05A, 32'h11F, fb);
      rdc(10'h080, 32'hFFFFFFFF, ib);
      chk(32'({hotplug_irq, wake_event, irq}), 32'h7);
      apb(1'h1, 10'h05A, fb);
      apb(1'h1, 10'h082, ib);
      rdc(10'h05A, 32'h11F, 32'h0);
    end
    rdc(10'h05A, 32'hFFFFFFFF, 32'hA0);
    // Master off, interrupt masked, slow completion
    slow <= 1'h1;
    apb(1'h1, 10'h081, 32'h0);
    apb(1'h1, 10'h058, 32'h101F);
    poke <= 5'h01;
    @(posedge mclk);
    poke <= 5'h00;
    tick(10);
    chk(32'({hotplug_irq, wake_event, irq}), 32'h2);
    apb(1'h1, 10'h081, 32'h3F);
    tick(3);
    chk(32'(irq), 32'h1);
    // Zero write keeps flags; a clear racing a new press loses
    apb(1'h1, 10'h05A, 32'h0);
    apb(1'h1, 10'h05A, 32'h1, 5'h01);
    rdc(10'h05A, 32'h11, 32'h11);
    // Clock enable low: a fault pulse in that window is never seen
    ce <= 1'h0;
    poke <= 5'h02;
    @(posedge mclk);
    poke <= 5'h00;
    tick(2);
    ce <= 1'h1;
    rdc(10'h05A, 32'h13, 32'h11);
    // Reset in mid-run
    rstn <= 1'h0;
    tick(5);
    rstn <= 1'h1;
    tick(2);
    chk(32'({hotplug_irq, wake_event, irq, attn_ind, pwr_ind, pwr_off}), 32'h0);
    rdc(10'h054, 32'hFFFFFFFF, 32'h0);
    rdc(10'h05A, 32'hFFFFFFFF, 32'h40);
    stop_test;
  end
endmodule
`default_nettype wire
